// File: common/sie_pkg.sv
// Constants for the system-control interrupt enable pair.
// Assumes a 32-bit AHB-Lite register bus and 12 interrupt sources.
package sie_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int SIE_NUM_SRC = 12;
  localparam int SIE_ADDR_W  = 8;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] SIE_OFS_ENABLE_CLEAR = 8'h00;
  localparam logic [7:0] SIE_OFS_ENABLE_SET   = 8'h04;
  localparam logic [7:0] SIE_OFS_IRQ_STATUS   = 8'h08;
  localparam logic [7:0] SIE_OFS_IRQ_MASK     = 8'h0c;

  // ----------------------------------------
  // Source bit positions in every register
  // ----------------------------------------
  localparam int SIE_BIT_BROWNOUT_SYNC_READY = 11;
  localparam int SIE_BIT_BROWNOUT_DETECT     = 10;
  localparam int SIE_BIT_BROWNOUT_READY      = 9;
  localparam int SIE_BIT_LOOP_REF_STOPPED    = 8;
  localparam int SIE_BIT_LOOP_COARSE_LOCK    = 7;
  localparam int SIE_BIT_LOOP_FINE_LOCK      = 6;
  localparam int SIE_BIT_LOOP_OUT_OF_BOUNDS  = 5;
  localparam int SIE_BIT_LOOP_READY          = 4;
  localparam int SIE_BIT_INT_8MHZ_READY      = 3;
  localparam int SIE_BIT_INT_32KHZ_READY     = 2;
  localparam int SIE_BIT_EXT_32KHZ_READY     = 1;
  localparam int SIE_BIT_CRYSTAL_READY       = 0;

  // Clear-register bits whose one sets instead of clears
  localparam logic [11:0] SIE_CLR_SETS_MASK = 12'h003;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [11:0] SIE_ENABLE_RST = 12'h000;
  localparam logic [11:0] SIE_MASK_RST   = 12'h000;
  localparam logic [11:0] SIE_STATUS_RST = 12'h000;
  localparam logic [31:0] SIE_RDATA_RST  = 32'h0000_0000;

  // ----------------------------------------
  // Bus encodings
  // ----------------------------------------
  localparam logic [2:0] SIE_HSIZE_BYTE = 3'h0;
  localparam logic [2:0] SIE_HSIZE_HALF = 3'h1;

endpackage

// File: hdl/sie_ahb_port.sv
// AHB-Lite address-phase capture for the enable pair.
// Assumes a single slave: hready is this slave's own hreadyout.
`timescale 1ns/1ps
module sie_ahb_port
  import sie_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  // AHB-Lite address phase
  input  wire logic                  hsel,
  input  wire logic [1:0]            htrans,
  input  wire logic [31:0]           haddr,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  output logic                       hreadyout,
  // Decoded access
  output logic                       rd_take,
  output logic [SIE_ADDR_W-1:0]      rd_index,
  output logic                       wr_commit,
  output logic [SIE_ADDR_W-1:0]      wr_index,
  output logic [3:0]                 wr_lanes
);

  typedef struct packed {
    logic                  wr_pend;
    logic [SIE_ADDR_W-1:0] wr_addr;
    logic [3:0]            lanes;
  } sie_port_t;

  sie_port_t cur_reg;
  sie_port_t cur_next;
  logic      take;
  logic [3:0] lane_sel;

  // Frozen clock enable stretches the data phase
  assign hreadyout = ce;
  assign take      = hsel & htrans[1] & hready;
  assign rd_take   = take & ~hwrite;
  // Word index: byte and halfword lanes of one register share it
  assign rd_index  = {haddr[SIE_ADDR_W-1:2], 2'b00};
  assign wr_commit = cur_reg.wr_pend & ce;
  assign wr_index  = cur_reg.wr_addr;
  assign wr_lanes  = cur_reg.lanes;

  // Byte lanes from size and low address bits
  always_comb
  begin
    if (hsize == SIE_HSIZE_BYTE)
      lane_sel = 4'h1 << haddr[1:0];
    else if (hsize == SIE_HSIZE_HALF)
      lane_sel = haddr[1] ? 4'hc : 4'h3;
    else
      lane_sel = 4'hf;
  end

  // Write held over to the data phase, where hwdata stands
  always_comb
  begin
    cur_next = cur_reg;
    if (hready)
    begin
      cur_next.wr_pend = take & hwrite;
      cur_next.wr_addr = {haddr[SIE_ADDR_W-1:2], 2'b00};
      cur_next.lanes   = lane_sel;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cur_reg <= '0;
    else if (ce)
      cur_reg <= cur_next;
  end

endmodule // sie_ahb_port

// File: hdl/sie_irq_status.sv
// Sticky event status with read-clear and masked interrupt line.
// Assumes events and the read strobe come from the same clock.
`timescale 1ns/1ps
module sie_irq_status
  import sie_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  // Events and software
  input  wire logic [SIE_NUM_SRC-1:0] events,
  input  wire logic                   rd_clear,
  input  wire logic [SIE_NUM_SRC-1:0] mask,
  // Results
  output logic [SIE_NUM_SRC-1:0]      status,
  output logic                        irq
);

  typedef struct packed {
    logic [SIE_NUM_SRC-1:0] status;
    logic                   irq;
  } sie_stat_t;

  sie_stat_t cur_reg;
  sie_stat_t cur_next;

  // Set wins over the read clear, so no event is lost
  always_comb
  begin
    cur_next        = cur_reg;
    cur_next.status = (rd_clear ? SIE_STATUS_RST : cur_reg.status) | events;
    cur_next.irq    = |(cur_next.status & mask);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cur_reg <= '0;
    else if (ce)
      cur_reg <= cur_next;
  end

  assign status = cur_reg.status;
  assign irq    = cur_reg.irq;

endmodule // sie_irq_status

// File: hdl/sie_enable_pair.sv
// Interrupt-enable pair (clear and set views of one enable set).
// Assumes AHB-Lite master on ref_clk; source flags and the write
// guard come from logic on the same clock.
//
// Overview of operation
// - A zero written to any enable position leaves that enable alone.
// - A one in bit 7 of the clear register clears the coarse-lock enable.
// - A one in bit 6 of the clear register clears the fine-lock enable.
// - A one in bit 5 of the clear register clears the out-of-bounds enable.
// - A one in bit 4 of the clear register clears the loop-ready enable.
// - A one in bit 3 of the clear register clears the 8 MHz ready enable.
// - A one in bit 2 of the clear register clears the 32 kHz ready enable.
// - A one in bit 1 or 0 of the clear register sets that enable.
// - A source requests an interrupt when its enable and its flag are set.
// - The set register holds bits 11:0, zero above, resets to zero, guarded.
// - Ones in bits 11, 10, 9 of the clear register clear brown-out enables.
// - A one in bit 8 of the clear register clears the ref-stopped enable.
// - Byte, halfword and word accesses reach every lane of both registers.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
module sie_enable_pair
  import sie_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // Sources and write guard
  input  wire logic [SIE_NUM_SRC-1:0] source_flag,
  input  wire logic                   peripheral_write_guard,
  // Results
  output logic [SIE_NUM_SRC-1:0]      irq_request,
  output logic [SIE_NUM_SRC-1:0]      interrupt_enable,
  output logic                        irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [SIE_NUM_SRC-1:0] enable;
    logic [SIE_NUM_SRC-1:0] mask;
    logic [SIE_NUM_SRC-1:0] request;
    logic [31:0]            rdata;
  } sie_state_t;

  localparam sie_state_t SIE_STATE_RST = '{
    enable:  SIE_ENABLE_RST,
    mask:    SIE_MASK_RST,
    request: SIE_ENABLE_RST,
    rdata:   SIE_RDATA_RST
  };

  sie_state_t             cur_reg;
  sie_state_t             cur_next;
  logic                   rd_take;
  logic [SIE_ADDR_W-1:0]  rd_index;
  logic                   wr_commit;
  logic [SIE_ADDR_W-1:0]  wr_index;
  logic [3:0]             wr_lanes;
  logic [31:0]            lane_bits;
  logic [SIE_NUM_SRC-1:0] wr_ones;
  logic [SIE_NUM_SRC-1:0] wr_keep;
  logic [SIE_NUM_SRC-1:0] status;
  logic                   status_rd;

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  sie_ahb_port u_port (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .ce        (ce),
    .hsel      (hsel),
    .htrans    (htrans),
    .haddr     (haddr),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hreadyout (hreadyout),
    .rd_take   (rd_take),
    .rd_index  (rd_index),
    .wr_commit (wr_commit),
    .wr_index  (wr_index),
    .wr_lanes  (wr_lanes)
  );

  // Every answer is OKAY; unmapped reads give zero
  assign hresp = 1'b0;

  // Expand byte lanes to one strobe per data bit
  generate
    for (genvar i = 0; i < 32; i++)
    begin : g_lane
      assign lane_bits[i] = wr_lanes[i / 8];
    end
  endgenerate

  // Only ones in selected lanes act; zeros never touch an enable
  assign wr_ones = hwdata[SIE_NUM_SRC-1:0] & lane_bits[SIE_NUM_SRC-1:0];
  assign wr_keep = ~lane_bits[SIE_NUM_SRC-1:0];

  // ----------------------------------------
  // Sticky status and interrupt line
  // ----------------------------------------
  assign status_rd = rd_take & (rd_index == SIE_OFS_IRQ_STATUS);

  sie_irq_status u_status (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .ce       (ce),
    .events   (cur_reg.request),
    .rd_clear (status_rd),
    .mask     (cur_reg.mask),
    .status   (status),
    .irq      (irq)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Read data is taken from the next enables, so a read right after
  // a write already sees that write.
  always_comb
  begin
    cur_next = cur_reg;
    if (wr_commit)
    begin
      case (wr_index)
        SIE_OFS_ENABLE_CLEAR:
        begin
          // Guard blocks enable writes; all ones act together
          if (!peripheral_write_guard)
          begin
            cur_next.enable = (cur_reg.enable & ~(wr_ones & ~SIE_CLR_SETS_MASK))
                            | (wr_ones & SIE_CLR_SETS_MASK);
          end
        end
        SIE_OFS_ENABLE_SET:
        begin
          if (!peripheral_write_guard)
          begin
            cur_next.enable = cur_reg.enable | wr_ones;
          end
        end
        SIE_OFS_IRQ_MASK:
        begin
          cur_next.mask = (cur_reg.mask & wr_keep) | wr_ones;
        end
        default:
        begin
          cur_next.mask = cur_reg.mask;
        end
      endcase
    end

    // Request follows enable and flag; zero enable suppresses it
    cur_next.request = cur_next.enable & source_flag;

    if (rd_take)
    begin
      case (rd_index)
        SIE_OFS_ENABLE_CLEAR,
        SIE_OFS_ENABLE_SET:
          cur_next.rdata = {20'h0_0000, cur_next.enable};
        SIE_OFS_IRQ_STATUS:
          cur_next.rdata = {20'h0_0000, status};
        SIE_OFS_IRQ_MASK:
          cur_next.rdata = {20'h0_0000, cur_next.mask};
        default:
          cur_next.rdata = SIE_RDATA_RST;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Low clock enable freezes everything, bus included
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cur_reg <= SIE_STATE_RST;
    else if (ce)
      cur_reg <= cur_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata           = cur_reg.rdata;
  assign irq_request      = cur_reg.request;
  assign interrupt_enable = cur_reg.enable;

endmodule // sie_enable_pair

// File: bench/sie_chk.sv
// Port checker for the interrupt-enable pair.
// Assumes one clock; bound onto every instance of the top.
`timescale 1ns/1ps
module sie_chk
  import sie_pkg::*;
(
  // Clock, reset, bus
  input wire logic                   ref_clk,
  input wire logic                   reset,
  input wire logic                   ce,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic [31:0]            hrdata,
  // Sources and results
  input wire logic [SIE_NUM_SRC-1:0] source_flag,
  input wire logic                   peripheral_write_guard,
  input wire logic [SIE_NUM_SRC-1:0] irq_request,
  input wire logic [SIE_NUM_SRC-1:0] interrupt_enable,
  input wire logic                   irq
);
  // ----
  // Decoded address phase
  // ----
  logic        take;
  logic        pair;
  logic        grd;
  logic [11:0] wd12;
  assign take = hsel && htrans[1] && hready;
  assign pair = (haddr[7:0] & 8'hfb) == 8'h00; // Clear or set view
  assign grd  = peripheral_write_guard;
  assign wd12 = hwdata[11:0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Unguarded word write: address edge, then data edge
  sequence wr_open(logic [7:0] a);
    take && hwrite && hsize == 3'h2 && haddr[7:0] == a && !grd ##1 !grd && ce;
  endsequence
  // Guarded write held across both edges and the next
  sequence wr_shut;
    take && hwrite && pair && grd ##1 grd ##1 grd;
  endsequence
  // ----
  // Properties
  // ----
  chk_set_ones: assert property (wr_open(8'h04) |=>
    interrupt_enable == ($past(interrupt_enable) | $past(wd12))) else $error("set view");
  chk_clr_ones: assert property (wr_open(8'h00) |=> interrupt_enable ==
    (($past(interrupt_enable) & ~($past(wd12) & 12'hffc)) | ($past(wd12) & 12'h003)))
    else $error("clear view");
  chk_guard_hold: assert property (wr_shut |-> $stable(interrupt_enable))
    else $error("guarded write moved enables");
  chk_req_match: assert property (ce && $past(ce) && $stable(source_flag)
    && $stable(interrupt_enable) |-> irq_request == (interrupt_enable & source_flag))
    else $error("request");
  chk_read_view: assert property (take && !hwrite && hsize == 3'h2 && pair
    |=> hrdata == {20'h0, interrupt_enable}) else $error("read view");
  chk_unmapped_zero: assert property (take && !hwrite && haddr[7:0] == 8'h10
    |=> hrdata == 32'h0) else $error("unmapped read");
  chk_status_clr: assert property (take && !hwrite && haddr[7:0] == 8'h08
    && irq_request == 12'h0 ##1 irq_request == 12'h0 |=> !irq) else $error("irq stuck");
  chk_resp_okay: assert property (hresp == 1'b0) else $error("response");
  chk_ready_ce: assert property (hreadyout == ce) else $error("ready");
endmodule // sie_chk

bind sie_enable_pair sie_chk i_chk (
  .ref_clk, .reset, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .source_flag, .peripheral_write_guard, .irq_request,
  .interrupt_enable, .irq
);

// File: bench/sysctrl_interrupt_enable_pair_test.sv
// Self-checking bench for the interrupt-enable pair.
// Assumes the pair is the bus's only slave; ce held high except in the clock-enable test.
`timescale 1ns/1ps
module sysctrl_interrupt_enable_pair_test;
  typedef struct packed { logic [7:0] a; logic [31:0] d; logic [11:0] e; } sie_row_t;
  logic        ref_clk, reset, ce, hsel, hwrite, hreadyout, hresp, irq, grd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [11:0] flag, req, en;
  int          errors = 0, check_count = 0, cycles = 0;
  // Write rows: view, data, enables expected after
  sie_row_t rows [13] = '{
    '{8'h00, 32'h001, 12'h001}, '{8'h00, 32'h002, 12'h003},
    '{8'h04, 32'hffc, 12'hfff}, '{8'h04, 32'h000, 12'hfff},
    '{8'h00, 32'h000, 12'hfff}, '{8'h04, 32'hfffff000, 12'hfff},
    '{8'h00, 32'h080, 12'hf7f}, '{8'h00, 32'h040, 12'hf3f},
    '{8'h00, 32'h020, 12'hf1f}, '{8'h00, 32'h010, 12'hf0f},
    '{8'h00, 32'h008, 12'hf07}, '{8'h00, 32'h004, 12'hf03},
    '{8'h00, 32'hf00, 12'h003}};

  sie_enable_pair i_dut (
    .ref_clk, .reset, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .source_flag(flag),
    .peripheral_write_guard(grd), .irq_request(req), .interrupt_enable(en), .irq
  );

  // Clock and hang guard; a bus wait never ends on its own
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single transfer; held until hready seen high at each phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] sz,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= sz;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 3'h2, 32'h0);
    cmp(rd, exp);
  endtask

  initial
  begin
    {reset, ce, hsel, hwrite, grd} = 5'b11000;
    htrans = 2'b00;
    hsize  = 3'h2;
    haddr  = 32'h0;
    hwdata = 32'h0;
    flag   = 12'h000;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      xfer(1'b1, rows[i].a, 3'h2, rows[i].d);
      rd_chk(8'h00, {20'h0, rows[i].e});
      rd_chk(8'h04, {20'h0, rows[i].e});
    end
    $display("test rows done");
    // Narrow lanes: byte 1 of set view, low half of clear view
    xfer(1'b1, 8'h05, 3'h0, 32'h0000_0f00);
    rd_chk(8'h04, 32'h0000_0f03);
    xfer(1'b1, 8'h00, 3'h1, 32'h0000_0300);
    rd_chk(8'h00, 32'h0000_0c03);
    // Guarded writes, then an unmapped place
    grd <= 1'b1;
    xfer(1'b1, 8'h04, 3'h2, 32'h0000_00fc);
    xfer(1'b1, 8'h00, 3'h2, 32'h0000_0c00);
    grd <= 1'b0;
    xfer(1'b1, 8'h10, 3'h2, 32'hffff_ffff);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h00, 32'h0000_0c03);
    $display("test lanes and guard done");
    // Flags with some enables off; mask all, then drain status
    xfer(1'b1, 8'h0c, 3'h2, 32'h0000_0fff);
    flag <= 12'h0f3;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp({20'h0, req}, 32'h0000_0003);
    cmp({31'h0, irq}, 32'h1);
    flag <= 12'h000;
    repeat (2) @(posedge ref_clk);
    rd_chk(8'h08, 32'h0000_0003);
    rd_chk(8'h08, 32'h0);
    #1;
    cmp({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    // Low clock enable freezes requests and stalls the bus
    ce   <= 1'b0;
    flag <= 12'h003;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp({20'h0, req}, 32'h0);
    cmp({31'h0, hreadyout}, 32'h0);
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp({20'h0, req}, 32'h0000_0003);
    flag <= 12'h000;
    $display("test clock enable done");
    // Second reset in mid-run
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd_chk(8'h04, 32'h0);
    cmp({20'h0, en}, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    rd_chk(8'h08, 32'h0);
    $display("test second reset done");
    close_out();
  end
endmodule // sysctrl_interrupt_enable_pair_test
